// *** include/rpc_pkg.sv ***
// Constants, offsets, field positions and reset values of the per-port
// control channel status register group.
// Assumes one register clock and an 8-bit local register access port.
package rpc_pkg;
  localparam int unsigned NUM_PORTS = 4;
  // Register offsets
  localparam logic [7:0] OFS_ERR_CTL    = 8'h46;
  localparam logic [7:0] OFS_ERR_STATUS = 8'h47;
  localparam logic [7:0] OFS_RSVD_A     = 8'h48;
  localparam logic [7:0] OFS_RSVD_B     = 8'h49;
  localparam logic [7:0] OFS_LINK_CAP   = 8'h4a;
  localparam logic [7:0] OFS_RAW_EMBED  = 8'h4b;
  localparam logic [7:0] OFS_PORT_SEL   = 8'h4c;
  // Status bit positions
  localparam int unsigned BIT_SEQ_ERR   = 5;
  localparam int unsigned BIT_MST_ERR   = 4;
  localparam int unsigned BIT_MST_TO    = 3;
  localparam int unsigned BIT_SLV_ERR   = 2;
  localparam int unsigned BIT_SLV_TO    = 1;
  localparam int unsigned BIT_RESP_ERR  = 0;
  // Error control and capability bits
  localparam int unsigned BIT_ENH_EN    = 5;
  localparam int unsigned BIT_ENC_CRC   = 4;
  // Port-select fields
  localparam int unsigned SEL_RD_LSB    = 4;
  localparam int unsigned SEL_WR_LSB    = 0;
  // Embedded type control fields
  localparam int unsigned EMB_CNT_LSB   = 6;
  localparam int unsigned EMB_ID_LSB    = 0;
  // Reset values and masks
  localparam logic [7:0] RST_ERR_CTL    = 8'h20;
  localparam logic [7:0] RST_STATUS     = 8'h00;
  localparam logic [7:0] RST_LINK_CAP   = 8'h00;
  localparam logic [7:0] RST_RAW_EMBED  = 8'h12;
  localparam logic [7:0] RST_PORT_SEL   = 8'h00;
  localparam logic [7:0] MASK_LINK_CAP  = 8'h10;
  localparam logic [7:0] MASK_STATUS    = 8'h3f;
  localparam logic [7:0] MASK_ERR_CTL   = 8'h20;
  localparam logic [7:0] RD_ZERO        = 8'h00;
  // Line tagging states
  typedef enum logic [1:0] {TAG_IDLE, TAG_COUNT, TAG_DONE} rpc_tag_state_t;
endpackage

// *** logic/rpc_line_tagger.sv ***
// Per-port data type tagger for the first lines of each raw-mode frame.
// Assumes frame_start and line_start pulses on ref_clk from the receiver.
`timescale 1ns/1ps
module rpc_line_tagger (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        raw_mode,
  input  wire logic [1:0]  embedded_line_count_select,
  input  wire logic [5:0]  embedded_type_value,
  input  wire logic [5:0]  raw_type_id,
  input  wire logic        frame_start,
  input  wire logic        line_start,
  output logic      [5:0]  line_type_id
);
  import rpc_pkg::*;

  rpc_tag_state_t state_ff;
  rpc_tag_state_t nxt_state;
  logic [1:0]     lines_ff;
  logic [1:0]     nxt_lines;
  logic [5:0]     type_ff;
  logic [5:0]     nxt_type;

  // Count long packets from frame start and choose the type per line
  always_comb begin
    nxt_state = state_ff;
    nxt_lines = lines_ff;
    nxt_type  = type_ff;
    case (state_ff)
      TAG_IDLE: begin
        if (frame_start) begin
          nxt_state = TAG_COUNT;
          nxt_lines = 2'h0;
        end else if (line_start) begin
          // Lines before the first frame start are never tagged
          nxt_type = raw_type_id;
        end
      end
      TAG_COUNT: begin
        if (frame_start) begin
          nxt_lines = 2'h0;
        end else if (line_start) begin
          // Tagging only applies to raw input; CSI-2 input passes untouched
          if (raw_mode && (lines_ff < embedded_line_count_select)) begin
            nxt_type  = embedded_type_value;
            nxt_lines = lines_ff + 2'h1;
          end else begin
            nxt_type  = raw_type_id;
            nxt_state = TAG_DONE;
          end
        end
      end
      TAG_DONE: begin
        if (frame_start) begin
          nxt_state = TAG_COUNT;
          nxt_lines = 2'h0;
        end else if (line_start) begin
          nxt_type = raw_type_id;
        end
      end
      default: nxt_state = TAG_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_ff <= TAG_IDLE;
      lines_ff <= 2'h0;
      type_ff  <= 6'h00;
    end else begin
      state_ff <= nxt_state;
      lines_ff <= nxt_lines;
      type_ff  <= nxt_type;
    end
  end

  assign line_type_id = type_ff;
endmodule

// *** logic/rpc_port_regs.sv ***
// Per-receive-port control channel status register group with port paging.
// Assumes a single-cycle local register access port on ref_clk, and event
// pulses from each port's control channel logic on the same clock.
// Function
// - Every register except the port-select register has one copy per port, steered by the port-select register.
// - Sequence flag mirrors port status when enhanced checks off, read-clears when on.
// - Master/slave link error flags latch while awaiting response; read clears.
// - Master/slave timeout flags latch on watchdog expiry; read clears.
// - Response data mismatch sets bit 0, cleared by read, enhanced only.
// - Status flags reset to zero; top two status bits read zero.
// - Capability bit 4 gates encoder CRC error flagging.
// - Embedded line count 0 forwards raw; 1 to 3 tags first lines.
// - Embedded type value replaces raw type id for first lines of frame.
// - Embedded tagging has no effect in CSI-2 input mode.
// - Reserved offsets 0x48 and 0x49 read zero.
// - Enhanced check enable resets to one; zero disables error detection except slave timeout and encoder CRC flagging.
// - Read-port field picks the read page; write bits broadcast writes.
`timescale 1ns/1ps
module rpc_port_regs #(
  parameter int unsigned PORTS = rpc_pkg::NUM_PORTS
) (
  input  wire logic              ref_clk,
  input  wire logic              reset,
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  input  wire logic [PORTS-1:0]  seq_error_event,
  input  wire logic [PORTS-1:0]  port_status_seq_error,
  input  wire logic [PORTS-1:0]  master_link_error_event,
  input  wire logic [PORTS-1:0]  slave_link_error_event,
  input  wire logic [PORTS-1:0]  master_timeout_event,
  input  wire logic [PORTS-1:0]  slave_timeout_event,
  input  wire logic [PORTS-1:0]  response_mismatch_event,
  input  wire logic [PORTS-1:0]  encoder_crc_error_event,
  output logic      [PORTS-1:0]  encoder_crc_error_flag,
  output logic      [PORTS-1:0]  enhanced_check_enable,
  input  wire logic [PORTS-1:0]  raw_mode,
  input  wire logic [PORTS*6-1:0] raw_type_id,
  input  wire logic [PORTS-1:0]  frame_start,
  input  wire logic [PORTS-1:0]  line_start,
  output logic      [PORTS*6-1:0] line_type_id
);
  import rpc_pkg::*;

  logic [7:0]       port_page_select_ff;
  logic [7:0]       nxt_port_page_select;
  logic [1:0]       rd_port;
  logic [7:0]       rdata_ff;
  logic [7:0]       nxt_rdata;
  logic [PORTS-1:0] wr_en;
  logic [PORTS-1:0] clr_rd;
  logic [7:0]       ctl_q   [PORTS];
  logic [7:0]       sts_q   [PORTS];
  logic [7:0]       cap_q   [PORTS];
  logic [7:0]       emb_q   [PORTS];

  assign rd_port = port_page_select_ff[SEL_RD_LSB +: 2];

  // Port-select register; held unpaged so every page shares it
  always_comb begin
    nxt_port_page_select = port_page_select_ff;
    if (reg_wr && (reg_addr == OFS_PORT_SEL)) begin
      nxt_port_page_select = {2'h0, reg_wdata[5:0]};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      port_page_select_ff <= RST_PORT_SEL;
    end else begin
      port_page_select_ff <= nxt_port_page_select;
    end
  end

  genvar p;
  generate
    for (p = 0; p < PORTS; p++) begin : g_port
      logic [7:0] ctl_ff;
      logic [7:0] nxt_ctl;
      logic [5:0] sts_ff;
      logic [5:0] nxt_sts;
      logic [7:0] cap_ff;
      logic [7:0] nxt_cap;
      logic [7:0] emb_ff;
      logic [7:0] nxt_emb;
      logic [5:0] ev;
      logic       enh;
      logic [5:0] sts_view;

      // Writes reach every page whose write bit is set; reads only one page
      assign wr_en[p]  = reg_wr && port_page_select_ff[SEL_WR_LSB + p];
      assign clr_rd[p] = reg_rd && (reg_addr == OFS_ERR_STATUS) && (rd_port == 2'(p));
      assign enh       = ctl_ff[BIT_ENH_EN];

      // Enhanced-only events are gated here; slave timeout always latches
      always_comb begin
        ev = 6'h00;
        ev[BIT_SEQ_ERR]  = enh && seq_error_event[p];
        ev[BIT_MST_ERR]  = enh && master_link_error_event[p];
        ev[BIT_SLV_ERR]  = enh && slave_link_error_event[p];
        ev[BIT_MST_TO]   = enh && master_timeout_event[p];
        ev[BIT_SLV_TO]   = slave_timeout_event[p];
        ev[BIT_RESP_ERR] = enh && response_mismatch_event[p];
      end

      // Register updates; set beats clear so no event is lost
      always_comb begin
        nxt_ctl = ctl_ff;
        nxt_cap = cap_ff;
        nxt_emb = emb_ff;
        nxt_sts = (clr_rd[p] ? 6'h00 : sts_ff) | ev;
        if (wr_en[p]) begin
          case (reg_addr)
            OFS_ERR_CTL:   nxt_ctl = reg_wdata;
            OFS_LINK_CAP:  nxt_cap = reg_wdata & MASK_LINK_CAP;
            OFS_RAW_EMBED: nxt_emb = reg_wdata;
            default:       nxt_ctl = ctl_ff;
          endcase
        end
      end

      always_ff @(posedge ref_clk) begin
        if (reset) begin
          ctl_ff <= RST_ERR_CTL;
          sts_ff <= RST_STATUS[5:0];
          cap_ff <= RST_LINK_CAP;
          emb_ff <= RST_RAW_EMBED;
        end else begin
          ctl_ff <= nxt_ctl;
          sts_ff <= nxt_sts;
          cap_ff <= nxt_cap;
          emb_ff <= nxt_emb;
        end
      end

      // With enhanced checks off the sequence bit is a live mirror
      always_comb begin
        sts_view = sts_ff;
        sts_view[BIT_SEQ_ERR] = enh ? sts_ff[BIT_SEQ_ERR] : port_status_seq_error[p];
      end

      assign ctl_q[p] = ctl_ff;
      assign sts_q[p] = {2'h0, sts_view};
      assign cap_q[p] = cap_ff;
      assign emb_q[p] = emb_ff;
      assign enhanced_check_enable[p]  = enh;
      assign encoder_crc_error_flag[p] = cap_ff[BIT_ENC_CRC] && encoder_crc_error_event[p];

      rpc_line_tagger u_tagger (
        .ref_clk                    (ref_clk),
        .reset                      (reset),
        .raw_mode                   (raw_mode[p]),
        .embedded_line_count_select (emb_ff[EMB_CNT_LSB +: 2]),
        .embedded_type_value        (emb_ff[EMB_ID_LSB +: 6]),
        .raw_type_id                (raw_type_id[p*6 +: 6]),
        .frame_start                (frame_start[p]),
        .line_start                 (line_start[p]),
        .line_type_id               (line_type_id[p*6 +: 6])
      );
    end
  endgenerate

  // Read mux from the page chosen by the read-port field
  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      case (reg_addr)
        OFS_ERR_CTL:    nxt_rdata = ctl_q[rd_port];
        OFS_ERR_STATUS: nxt_rdata = sts_q[rd_port] & MASK_STATUS;
        OFS_RSVD_A:     nxt_rdata = RD_ZERO;
        OFS_RSVD_B:     nxt_rdata = RD_ZERO;
        OFS_LINK_CAP:   nxt_rdata = cap_q[rd_port];
        OFS_RAW_EMBED:  nxt_rdata = emb_q[rd_port];
        OFS_PORT_SEL:   nxt_rdata = port_page_select_ff;
        default:        nxt_rdata = RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_ff <= RD_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
endmodule

// *** verification/rpc_port_regs_properties.sv ***
// Checker of the port register group, bound to its top ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
module rpc_port_regs_props #(
  parameter int unsigned PORTS = 4
) (
  input wire logic             ref_clk,
  input wire logic             reset,
  input wire logic [7:0]       reg_addr,
  input wire logic             reg_rd,
  input wire logic [7:0]       reg_rdata,
  input wire logic [PORTS-1:0] encoder_crc_error_event,
  input wire logic [PORTS-1:0] encoder_crc_error_flag,
  input wire logic [PORTS-1:0] enhanced_check_enable,
  input wire logic [PORTS-1:0] raw_mode,
  input wire logic [PORTS-1:0] line_start,
  input wire logic [PORTS*6-1:0] raw_type_id,
  input wire logic [PORTS*6-1:0] line_type_id
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // A read strobe at one offset, then idle cycles that must not disturb data
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  sequence s_idle;
    !reg_rd [*3];
  endsequence
  AST_RSVD_A: assert property (s_rd(8'h48) |=> reg_rdata == 8'h00) else $error("reserved a nonzero");
  AST_RSVD_B: assert property (s_rd(8'h49) |=> reg_rdata == 8'h00) else $error("reserved b nonzero");
  AST_STS_TOP: assert property (s_rd(8'h47) |=> reg_rdata[7:6] == 2'b00) else $error("status top set");
  AST_CAP_RSVD: assert property (s_rd(8'h4a) |=> (reg_rdata & 8'hef) == 8'h00) else $error("cap bits");
  AST_SEL_TOP: assert property (s_rd(8'h4c) |=> reg_rdata[7:6] == 2'b00) else $error("select top set");
  AST_HOLD: assert property (s_rd(8'h47) ##1 s_idle |-> $stable(reg_rdata)) else $error("read data moved");
  AST_CRC: assert property ((encoder_crc_error_flag & ~encoder_crc_error_event) == '0) else $error("crc flag");
  AST_ENH_RST: assert property ($fell(reset) |-> &enhanced_check_enable) else $error("enh reset");
  // Line type must stay the programmed raw id in CSI-2 mode
  AST_CSI_RAW: assert property (line_start[0] && !raw_mode[0] |=>
    line_type_id[5:0] == $past(raw_type_id[5:0])) else $error("csi tagged");
endmodule
bind rpc_port_regs rpc_port_regs_props #(.PORTS(PORTS)) u_props (.ref_clk, .reset, .reg_addr, .reg_rd,
  .reg_rdata, .encoder_crc_error_event, .encoder_crc_error_flag, .enhanced_check_enable, .raw_mode,
  .line_start, .raw_type_id, .line_type_id);

// *** verification/rpc_far_side.sv ***
// Far-side stand-in: control channel events from the remote serializer.
// Assumes the bench requests events on port 0 between clock edges.
`timescale 1ns/1ps
module rpc_far_side #(
  parameter int unsigned PORTS = 4
) (
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  wire logic [6:0]         fire,
  output logic      [7*PORTS-1:0] event_ff
);
  logic [7*PORTS-1:0] nxt_event;
  // Pulses last one cycle; a held event would hide clear-on-read faults
  always_comb begin
    nxt_event = '0;
    for (int i = 0; i < 7; i++) begin
      // CRC events stand for an encoder whose CRC disable bit software has cleared
      nxt_event[i*PORTS] = fire[i] & ~reset;
    end
  end
  always_ff @(posedge ref_clk) begin
    event_ff <= nxt_event;
  end
endmodule

// *** verification/tb_rx_port_control_channel_status_regs.sv ***
// Self-checking bench of the per-port status registers and line tagger.
// Assumes the far-side model for events; the bench drives registers and video.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module tb_rx_port_control_channel_status_regs;
  import rpc_pkg::*;
  logic        ref_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0]  reg_addr = '0, reg_wdata = '0, reg_rdata;
  logic [3:0]  pst = '0, raw_mode = '0, frame_start = '0, line_start = '0, crc_flag, enh;
  logic [23:0] raw_type_id = {4{6'h2b}}, line_type_id;
  logic [27:0] ev;
  logic [6:0]  fire = '0;
  int          err_count = 0, checks = 0, cyc = 0;
  // Rows: write flag, offset, data written or expected on read
  logic [16:0] rows [24] = '{17'h04c00, 17'h04620, 17'h04700, 17'h04800, 17'h04900, 17'h04a00,
    17'h04b12, 17'h07f00, 17'h14c0f, 17'h14aff, 17'h04a10, 17'h14bc5, 17'h04bc5, 17'h148ff,
    17'h04800, 17'h147ff, 17'h04700, 17'h14c31, 17'h04c31, 17'h14a00, 17'h04a10, 17'h14c0f,
    17'h04c0f, 17'h14b12};
  rpc_port_regs u_dut (.ref_clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .seq_error_event(ev[3:0]), .port_status_seq_error(pst), .master_link_error_event(ev[7:4]),
    .slave_link_error_event(ev[11:8]), .master_timeout_event(ev[15:12]),
    .slave_timeout_event(ev[19:16]), .response_mismatch_event(ev[23:20]),
    .encoder_crc_error_event(ev[27:24]), .encoder_crc_error_flag(crc_flag),
    .enhanced_check_enable(enh), .raw_mode, .raw_type_id, .frame_start, .line_start, .line_type_id);
  rpc_far_side u_far (.ref_clk, .reset, .fire, .event_ff(ev));
  always begin
    #12.5 ref_clk = ~ref_clk;
  end
  // Cut a hang short well past the expected run of under two hundred cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge ref_clk);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge ref_clk);
    reg_rd = 0;
    q = reg_rdata;
  endtask
  // Event pulse from the far side; returns the CRC flag while it is high
  task automatic pulse(input logic [6:0] m, output logic [3:0] f);
    @(negedge ref_clk);
    fire = m;
    @(negedge ref_clk);
    fire = '0;
    f = crc_flag;
  endtask
  task automatic strobe(input bit frm, input logic [5:0] e);
    @(negedge ref_clk);
    frame_start[0] = frm;
    line_start[0] = !frm;
    @(negedge ref_clk);
    frame_start = '0;
    line_start = '0;
    if (!frm) `CHK("line", e, line_type_id[5:0])
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] q;
    logic [3:0] f;
    repeat (16) @(negedge ref_clk);
    reset = 0;
    foreach (rows[i]) begin
      if (rows[i][16]) begin
        wr(rows[i][15:8], rows[i][7:0]);
      end else begin
        rd(rows[i][15:8], q);
        `CHK("reg", rows[i][7:0], q)
      end
    end
    pulse(7'h3f, f);
    rd(8'h47, q);
    `CHK("status", 8'h3f, q)
    rd(8'h47, q);
    `CHK("cleared", 8'h00, q)
    // Slave timeout lands on the same edge as the clearing read
    @(negedge ref_clk);
    fire = 7'h10;
    @(negedge ref_clk);
    fire = '0;
    reg_addr = 8'h47;
    reg_rd = 1;
    @(negedge ref_clk);
    reg_rd = 0;
    `CHK("race read", 8'h00, reg_rdata)
    rd(8'h47, q);
    `CHK("kept", 8'h02, q)
    wr(8'h46, 8'h00);
    `CHK("enh", 4'h0, enh)
    pst[0] = 1;
    pulse(7'h3f, f);
    rd(8'h47, q);
    `CHK("enh off", 8'h22, q)
    rd(8'h47, q);
    `CHK("mirror", 8'h20, q)
    pst = '0;
    wr(8'h46, 8'h20);
    pulse(7'h40, f);
    `CHK("crc off", 4'h0, f)
    wr(8'h4a, 8'h10);
    pulse(7'h40, f);
    `CHK("crc on", 4'h1, f)
    // Every line count in raw mode, then count three in CSI-2 mode
    raw_mode = 4'h1;
    for (int c = 0; c < 5; c++) begin
      wr(8'h4b, {(c == 4) ? 2'b11 : 2'(c), 6'h15});
      if (c == 4) raw_mode = '0;
      strobe(1, 6'h00);
      for (int l = 0; l < 4; l++) begin
        strobe(0, (raw_mode[0] && l < c) ? 6'h15 : 6'h2b);
      end
    end
    // Mid-run reset must drop a latched flag and restore overwritten defaults
    pulse(7'h01, f);
    @(negedge ref_clk);
    reset = 1;
    repeat (2) @(negedge ref_clk);
    reset = 0;
    rd(8'h47, q);
    `CHK("rst status", 8'h00, q)
    rd(8'h4b, q);
    `CHK("rst embed", 8'h12, q)
    rd(8'h4c, q);
    `CHK("rst select", 8'h00, q)
    tally_and_finish();
  end
endmodule
